// File: rtl/dio_defines.svh
/*
 * constants of the dual three-port digital i/o card: decoder, offsets,
 * control word codes and reset values.
 * assumes inclusion by bare name from the package; the design uses its macros.
 */
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

`define SWITCH_COUNT        7
`define SWITCH_DEFAULT      7'h20
`define ADDR_HIGH           9
`define ADDR_LOW            3
`define OFFSET_PORT_A_FIRST  3'h0
`define OFFSET_PORT_B_FIRST  3'h1
`define OFFSET_PORT_C_FIRST  3'h2
`define OFFSET_CTRL_FIRST    3'h3
`define OFFSET_PORT_A_SECOND 3'h4
`define OFFSET_PORT_B_SECOND 3'h5
`define OFFSET_PORT_C_SECOND 3'h6
`define OFFSET_CTRL_SECOND   3'h7
`define CTRL_MODE_SET_BIT   7
`define CTRL_A_IN_BIT       4
`define CTRL_CU_IN_BIT      3
`define CTRL_B_IN_BIT       1
`define CTRL_CL_IN_BIT      0
`define CTRL_ALL_INPUT      8'h9b
`define BYTE_ZERO           8'h00

`endif

// File: rtl/dio_pkg.sv
/*
 * types shared by the digital i/o card design.
 * assumes dio_defines.svh on the include path.
 */
package dio_pkg;
`include "dio_defines.svh"
   typedef logic [7:0] byte_type;
   typedef logic [2:0] offset_type;
   typedef logic [`SWITCH_COUNT-1:0] switch_type;
endpackage : dio_pkg

// File: rtl/isa_dual_ppi_digital_io.sv
/*
 * host-side logic of a dual three-port digital i/o card on an 8-bit
 * isa i/o bus: base address decode, two control words, six channel ports.
 * assumes bus strobes synchronous to core_clk and one-byte accesses.
 */
// Functional notes
// - base address is sum of open switch weights, 8h up to 200h
// - shipped switch setting gives base 100h, only switch five open
// - card answers all eight consecutive byte addresses from base
// - first circuit ports at offsets 0-2, second at 4-6
// - each port is one byte, one bit per field channel
// - writing an output port switches each channel per bit
// - read gives input levels, or latched state for output ports
// - one bit switches a channel on; 255 turns all on
// - control 80h on first circuit makes all ports outputs
// - control 89h on first circuit makes third port input
// - control 8bh on first circuit makes second, third ports inputs
// - control 9bh on first makes all inputs; second gets 80h
// - control 82h on second circuit makes second port input
// - control 92h on second makes first and second ports inputs
// - control 9bh on second circuit makes all ports inputs
// - only 8-bit i/o cycles reach the card
// - field inputs are active low
`timescale 1ns/1ns
`default_nettype none

module isa_dual_ppi_digital_io
   import dio_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire switch_type  base_switch_open,
   input  wire logic [9:0]  io_addr,
   input  wire logic        io_write,
   input  wire logic        io_read,
   input  wire byte_type    io_wdata,
   output logic             io_card_selected,
   output byte_type         io_rdata,
   output logic             io_rdata_valid,
   input  wire byte_type    field_in_n [6],
   output byte_type         field_out [6],
   output logic [5:0]       port_is_input
);

////////////////////////////////////////////////////////////////////////
// reset release
logic       rst_meta_n;
logic       rst_n;

always_ff @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
   end
   else
   begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
   end
end

////////////////////////////////////////////////////////////////////////
// address decode
logic       hit;
offset_type offset;

// open switch k carries weight 8h << k, so the pattern is address 9..3
always_comb
begin
   hit    = (io_addr[`ADDR_HIGH:`ADDR_LOW] == base_switch_open);
   offset = io_addr[`ADDR_LOW-1:0];
end

////////////////////////////////////////////////////////////////////////
// control words and output latches
byte_type   out_latch [6];
logic [5:0] is_input;
byte_type   next_out_latch [6];
logic [5:0] next_is_input;
logic       circuit;
logic [2:0] base_idx;

always_comb
begin
   for (int i = 0; i < 6; i++)
   begin
      next_out_latch[i] = out_latch[i];
   end
   next_is_input = is_input;
   circuit  = offset[2];
   base_idx = circuit ? 3'h3 : 3'h0;
   if (io_write && hit)
   begin
      if ({1'b0, offset[1:0]} == `OFFSET_CTRL_FIRST)
      begin
         if (io_wdata[`CTRL_MODE_SET_BIT])
         begin
            // direction bits: a, b, c-upper/c-lower both needed for c
            next_is_input[base_idx]
               = io_wdata[`CTRL_A_IN_BIT];
            next_is_input[base_idx + 3'h1]
               = io_wdata[`CTRL_B_IN_BIT];
            next_is_input[base_idx + 3'h2]
               = io_wdata[`CTRL_CU_IN_BIT]
                 & io_wdata[`CTRL_CL_IN_BIT];
            // mode set clears all outputs of that circuit
            for (int j = 0; j < 3; j++)
            begin
               next_out_latch[base_idx + 3'(j)] = `BYTE_ZERO;
            end
         end
      end
      else
      begin
         // offsets 0-2 and 4-6: bit one turns channel on
         next_out_latch[base_idx + {1'b0, offset[1:0]}]
            = io_wdata;
      end
   end
end

always_ff @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      for (int i = 0; i < 6; i++)
      begin
         out_latch[i] <= `BYTE_ZERO;
      end
      is_input <= 6'h3f;
   end
   else
   begin
      out_latch <= next_out_latch;
      is_input  <= next_is_input;
   end
end

////////////////////////////////////////////////////////////////////////
// read path and pin registers
byte_type   next_rdata;
logic       next_rvalid;
logic       next_selected;
logic [2:0] ridx;

always_comb
begin
   ridx          = (offset[2] ? 3'h3 : 3'h0) + {1'b0, offset[1:0]};
   next_selected = hit;
   next_rvalid   = io_read && hit;
   next_rdata    = `BYTE_ZERO;
   if (io_read && hit && {1'b0, offset[1:0]} != `OFFSET_CTRL_FIRST)
   begin
      // input level is inverted so a driven channel reads as one
      next_rdata = is_input[ridx] ? ~field_in_n[ridx]
                                  : out_latch[ridx];
   end
end

always_ff @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      io_card_selected <= 1'b0;
      io_rdata         <= `BYTE_ZERO;
      io_rdata_valid   <= 1'b0;
      port_is_input    <= 6'h3f;
      for (int i = 0; i < 6; i++)
      begin
         field_out[i] <= `BYTE_ZERO;
      end
   end
   else
   begin
      io_card_selected <= next_selected;
      io_rdata         <= next_rdata;
      io_rdata_valid   <= next_rvalid;
      port_is_input    <= next_is_input;
      for (int i = 0; i < 6; i++)
      begin
         field_out[i] <= next_is_input[i] ? `BYTE_ZERO
                                          : next_out_latch[i];
      end
   end
end

endmodule : isa_dual_ppi_digital_io
`default_nettype wire

// File: verification/dio_chk_properties.sv
/* port checker of the i/o card.
   assumes the top module ports. */
`timescale 1ns/1ns
`default_nettype none
module dio_chk
   import dio_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire switch_type base_switch_open,
   input wire logic [9:0] io_addr,
   input wire logic       io_write,
   input wire logic       io_read,
   input wire byte_type   io_wdata,
   input wire logic       io_card_selected,
   input wire byte_type   io_rdata,
   input wire logic       io_rdata_valid,
   input wire byte_type   field_in_n [6],
   input wire byte_type   field_out [6],
   input wire logic [5:0] port_is_input
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   wire       m = io_addr[9:3] == base_switch_open;
   wire       w = io_write && m;
   wire       r = io_read && m;
   wire [2:0] o = io_addr[2:0];
   property p_sel; 1'b1 |=> io_card_selected == $past(m); endproperty
   a_sel: assert property (p_sel) else $error("sel");
   property p_rv; r |=> io_rdata_valid; endproperty
   a_rv: assert property (p_rv) else $error("rv");
   property p_norv; !r |=> !io_rdata_valid; endproperty
   a_norv: assert property (p_norv) else $error("norv");
   property p_wr;
      w && o == 3'h0 && !port_is_input[0] |=> field_out[0] == $past(io_wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("wr");
   property p_in;
      r && o == 3'h1 && port_is_input[1] |=> io_rdata == ~$past(field_in_n[1]);
   endproperty
   a_in: assert property (p_in) else $error("in");
   property p_c80;
      w && o == 3'h3 && io_wdata == 8'h80 |=> port_is_input[2:0] == 3'h0;
   endproperty
   a_c80: assert property (p_c80) else $error("c80");
   property p_c9b;
      w && o == 3'h7 && io_wdata == 8'h9b |=> port_is_input[5:3] == 3'h7;
   endproperty
   a_c9b: assert property (p_c9b) else $error("c9b");
   property p_hold; !io_write |=> $stable(port_is_input); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   c_rd: cover property (r && port_is_input[0]);
   c_wr: cover property (w && o == 3'h0);
   c_miss: cover property (io_read && !m);
endmodule : dio_chk
`default_nettype wire

// File: verification/field_model.sv
/* field side: drives the active low inputs.
   assumes a level byte from the bench. */
`timescale 1ns/1ns
`default_nettype none
module field_model
   import dio_pkg::*;
(
   input wire byte_type level,
   output byte_type     field_in_n [6]
);
   always_comb
   begin
      for (int k = 0; k < 6; k++)
         field_in_n[k] = ~(level ^ byte_type'(k));
   end
endmodule : field_model
`default_nettype wire

// File: verification/isa_dual_ppi_digital_io_test.sv
/* self-checking bench of the i/o card.
   assumes the design, field_model and dio_chk. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,a) begin compares++; if ((a) !== (e)) begin err_count++; \
$display("[FAIL] %s exp %h got %h", n, e, a); end end
module isa_dual_ppi_digital_io_test
   import dio_pkg::*;
;
   logic       core_clk = 0, arst_n = 0, io_write = 0, io_read = 0;
   logic [9:0] io_addr = 10'h000;
   byte_type   io_wdata = 8'h00, lvl = 8'h3c, io_rdata;
   logic       io_card_selected, io_rdata_valid;
   logic [5:0] port_is_input;
   logic [2:0] o;
   logic [6:0] sw = `SWITCH_DEFAULT;
   byte_type   field_in_n [6], field_out [6];
   int         err_count = 0, compares = 0;
   byte_type   cw [7] = '{8'h89, 8'h8b, 8'h9b, 8'h80, 8'h82, 8'h92, 8'h9b};
   logic [2:0] dir [7] = '{3'h4, 3'h6, 3'h7, 3'h0, 3'h2, 3'h3, 3'h7};
   isa_dual_ppi_digital_io DUT (.core_clk, .arst_n,
      .base_switch_open(sw), .io_addr, .io_write, .io_read, .io_wdata,
      .io_card_selected, .io_rdata, .io_rdata_valid, .field_in_n,
      .field_out, .port_is_input);
   field_model FM (.level(lvl), .field_in_n);
   task automatic wr(input logic [9:0] a, input byte_type d);
      @(negedge core_clk) {io_addr, io_wdata, io_write} = {a, d, 1'b1};
      @(negedge core_clk) io_write = 0;
   endtask : wr
   task automatic rd(input logic [9:0] a, input byte_type e, input logic v);
      @(negedge core_clk) {io_addr, io_read} = {a, 1'b1};
      @(negedge core_clk) io_read = 0;
      `CHK("valid", v, io_rdata_valid)
      `CHK("rdata", e, io_rdata)
   endtask : rd
   task automatic test_done;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   initial
      forever #4 core_clk = ~core_clk;
   initial
   begin
      #100000 err_count++;
      test_done;
   end
   initial
   begin
      repeat (6) @(negedge core_clk);
      `CHK("dir rst", 6'h3f, port_is_input)
      arst_n = 1;
      repeat (3) @(negedge core_clk);
      for (int i = 0; i < 7; i++)
      begin
         wr(i < 4 ? 10'h103 : 10'h107, cw[i]);
         o = i < 4 ? port_is_input[2:0] : port_is_input[5:3];
         `CHK("dir", dir[i], o)
      end
      for (int p = 0; p < 2; p++)
      begin
         wr(10'h103, p ? 8'h9b : 8'h80);
         wr(10'h107, p ? 8'h80 : 8'h9b);
         for (int i = 0; i < 6; i++)
         begin
            o = 3'(i + (i > 2));
            if ((i > 2) == p)
            begin
               wr(10'h100 + o, 8'hff >> i);
               `CHK("out", 8'hff >> i, field_out[i])
               rd(10'h100 + o, 8'hff >> i, 1);
            end
            else
               rd(10'h100 + o, lvl ^ i, 1);
         end
      end
      rd(10'h107, 8'h00, 1);
      wr(10'h10c, 8'h00);
      `CHK("miss", 8'h1f, field_out[3])
      rd(10'h0ff, 8'h00, 0);
      sw = 7'h66;
      wr(10'h334, 8'h5a);
      `CHK("moved", 8'h5a, field_out[3])
      rd(10'h334, 8'h5a, 1);
      rd(10'h100, 8'h00, 0);
      test_done;
   end
endmodule : isa_dual_ppi_digital_io_test
bind isa_dual_ppi_digital_io dio_chk u_chk (.*);
`default_nettype wire
